// [src/reset_pin_manager_defs.vh]
// constants for the reset pin manager: register map, field layout, codes and counts
// assumes inclusion by bare name from the design files
`ifndef RESET_PIN_MANAGER_DEFS_VH
`define RESET_PIN_MANAGER_DEFS_VH

// register byte offsets
`define OFS_CONTROL 4'h0
`define OFS_MODE 4'h4
`define OFS_STATUS 4'h8
`define OFS_IRQ_STATUS 4'hc
`define ADDR_W 4

// control register command bits (write only)
`define CTL_PROC 0
`define CTL_PERIPH 2
`define CTL_EXT 3

// mode register fields
`define MODE_URST_EN 0
`define MODE_URST_IRQ_EN 4
`define MODE_LEN_LSB 8
`define MODE_LEN_MSB 11
`define MODE_RESET 32'h0000_0001
`define MODE_MASK 32'h0000_0f11

// status register fields
`define STS_SEEN 0
`define STS_TYPE_LSB 8
`define STS_TYPE_MSB 10
`define STS_PIN_LEVEL 16
`define STS_SW_BUSY 17

// irq status fields; the mask register shares the layout in the upper half of the same word, from bit 16
`define OFS_IRQ_MASK 4'h0
`define IRQ_PIN 0
`define IRQ_EXT_DONE 1
`define IRQ_W 2

// last reset type codes
`define TYPE_POWER_UP 3'h0
`define TYPE_SOFT 3'h3
`define TYPE_USER 3'h4

// timing in slow clock cycles
`define URST_RESYNC_CYC 3'h2
`define URST_START_CYC 3'h3
`define SW_RESET_CYC 3'h3
`define EXT_CNT_W 17
`define EXT_CNT_ONE 17'h0_0001

// axi responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// [src/pin_sync.v]
// three-flop synchroniser with agreement filter for an asynchronous pin
// assumes the pin is quiet for at least two clocks around a real change
`timescale 1ns/1ps
module pin_sync #(
  parameter RESET_LEVEL = 1'b1
) (
  input wire aclk,
  input wire aresetn,
  input wire pin_in,
  output reg level_r
);

reg meta_r;
reg sync2_r;
reg sync3_r;

// first flop feeds only the second; level moves when stages two and three agree
always @(posedge aclk) begin
  if (!aresetn) begin
    meta_r <= RESET_LEVEL;
    sync2_r <= RESET_LEVEL;
    sync3_r <= RESET_LEVEL;
    level_r <= RESET_LEVEL;
  end else begin
    meta_r <= pin_in;
    sync2_r <= meta_r;
    sync3_r <= sync2_r;
    if (sync2_r == sync3_r) begin
      level_r <= sync3_r;
    end
  end
end

endmodule // pin_sync

// [src/reset_pin_manager.v]
// reset pin manager: reset lines, open-drain reset pin shaping and sampling, axi4-lite regs
// assumes aclk is the slow clock and a reset state manager drives ext_reset_req
// Functional notes
// RULE1: one slow clock; processor, peripheral and pin reset outputs generated.
// RULE2: watchdog reset follows processor reset exactly.
// RULE3: peripheral reset is a separate output for all peripherals.
// RULE4: processor, peripheral and pin resets assertable alone or together.
// RULE5: last reset type is recorded and readable by software.
// RULE6: pin sampled on slow clock; driven low on external reset request.
// RULE7: sampled low pin signals a user reset request.
// RULE8: user reset enable cleared means a low pin starts no user reset.
// RULE9: current pin level readable in status at any time.
// RULE10: sticky flag set on pin assertion, cleared by status read.
// RULE11: irq enable set makes pin assertion raise interrupt instead of reset.
// RULE12: external request holds pin low for the programmed length.
// RULE13: low time is two to the power of length plus one cycles.
// RULE14: user reset ends after two resync and three startup cycles.
// RULE15: internal resets stay asserted while something holds the pin low.
// RULE16: processor release after user reset loads user reset type code.
// RULE17: reset outputs active low; pin only pulled low or released.
`timescale 1ns/1ps
`include "reset_pin_manager_defs.vh"
module reset_pin_manager (
  input wire aclk,
  input wire aresetn,
  input wire [`ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire ext_reset_req,
  output reg user_reset_req,
  output reg proc_reset_n,
  output reg periph_reset_n,
  output wire watchdog_reset_n,
  input wire reset_pin_i,
  output wire reset_pin_o,
  output reg reset_pin_oe,
  output wire irq
);

localparam [3:0] U_IDLE = 4'b0001;
localparam [3:0] U_HOLD = 4'b0010;
localparam [3:0] U_RESYNC = 4'b0100;
localparam [3:0] U_START = 4'b1000;

////////////////////////////////////////////////////////////////////////////////
// pin sampling

wire pin_level;
reg pin_prev_r;
wire pin_fall;

// RULE6 pin sampled
pin_sync #(
  .RESET_LEVEL(1'b1)
) u_pin_sync (
  .aclk(aclk),
  .aresetn(aresetn),
  .pin_in(reset_pin_i),
  .level_r(pin_level)
);

always @(posedge aclk) begin
  if (!aresetn) begin
    pin_prev_r <= 1'b1;
  end else begin
    pin_prev_r <= pin_level;
  end
end

assign pin_fall = pin_prev_r & ~pin_level;

////////////////////////////////////////////////////////////////////////////////
// registers and bus decode

reg [31:0] mode_r;
reg [`IRQ_W-1:0] irq_sts_r;
reg [`IRQ_W-1:0] irq_mask_r;
reg seen_r;
reg [2:0] type_r;
reg [2:0] sw_cnt_r;
reg sw_proc_r;
reg sw_periph_r;
reg [31:0] wmask;
wire wr_go;
wire rd_go;
wire ctl_wr;
wire mode_wr;
wire irq_wr;
wire mask_wr;
wire sts_rd;
wire [3:0] len_field;
wire urst_en;
wire urst_irq_en;

assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
assign s_axi_awready = wr_go;
assign s_axi_wready = wr_go;
assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
assign s_axi_arready = ~s_axi_rvalid;
assign ctl_wr = wr_go & (s_axi_awaddr == `OFS_CONTROL) & s_axi_wstrb[0];
assign mode_wr = wr_go & (s_axi_awaddr == `OFS_MODE);
assign irq_wr = wr_go & (s_axi_awaddr == `OFS_IRQ_STATUS) & s_axi_wstrb[0];
// the mask sits in the upper half of the irq word so the map stays four words
assign mask_wr = wr_go & (s_axi_awaddr == `OFS_IRQ_STATUS) & s_axi_wstrb[2];
assign sts_rd = rd_go & (s_axi_araddr == `OFS_STATUS);
assign len_field = mode_r[`MODE_LEN_MSB:`MODE_LEN_LSB];
assign urst_en = mode_r[`MODE_URST_EN];
assign urst_irq_en = mode_r[`MODE_URST_IRQ_EN];

always @* begin
  wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
end

always @(posedge aclk) begin
  if (!aresetn) begin
    mode_r <= `MODE_RESET;
    irq_mask_r <= {`IRQ_W{1'b0}};
  end else begin
    if (mode_wr) begin
      mode_r <= ((mode_r & ~wmask) | (s_axi_wdata & wmask)) & `MODE_MASK;
    end
    if (mask_wr) begin
      irq_mask_r <= s_axi_wdata[16+`IRQ_W-1:16];
    end
  end
end

// write response; unmapped offsets answer slverr
always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_bvalid <= 1'b0;
    s_axi_bresp <= `RESP_OKAY;
  end else if (wr_go) begin
    s_axi_bvalid <= 1'b1;
    s_axi_bresp <= (s_axi_awaddr[1:0] != 2'b00) ? `RESP_SLVERR : `RESP_OKAY;
  end else if (s_axi_bready) begin
    s_axi_bvalid <= 1'b0;
  end
end

// read data; all four words mapped, misaligned reads answer slverr
always @(posedge aclk) begin
  if (!aresetn) begin
    s_axi_rvalid <= 1'b0;
    s_axi_rresp <= `RESP_OKAY;
    s_axi_rdata <= 32'h0000_0000;
  end else if (rd_go) begin
    s_axi_rvalid <= 1'b1;
    s_axi_rresp <= `RESP_OKAY;
    s_axi_rdata <= 32'h0000_0000;
    case (s_axi_araddr)
      `OFS_MODE: begin
        s_axi_rdata <= mode_r;
      end
      // RULE5 type readable
      `OFS_STATUS: begin
        s_axi_rdata[`STS_SEEN] <= seen_r;
        s_axi_rdata[`STS_TYPE_MSB:`STS_TYPE_LSB] <= type_r;
        // RULE9 live pin level
        s_axi_rdata[`STS_PIN_LEVEL] <= pin_level;
        s_axi_rdata[`STS_SW_BUSY] <= (sw_cnt_r != 3'h0);
      end
      `OFS_IRQ_STATUS: begin
        s_axi_rdata[`IRQ_W-1:0] <= irq_sts_r;
        s_axi_rdata[16+`IRQ_W-1:16] <= irq_mask_r;
      end
      `OFS_CONTROL: begin
        s_axi_rdata <= 32'h0000_0000;
      end
      default: begin
        s_axi_rresp <= `RESP_SLVERR;
      end
    endcase
  end else if (s_axi_rready) begin
    s_axi_rvalid <= 1'b0;
  end
end

////////////////////////////////////////////////////////////////////////////////
// software reset commands

wire sw_busy;
wire sw_start;
wire sw_ext;

assign sw_busy = (sw_cnt_r != 3'h0);
// writes while a command runs are ignored
assign sw_start = ctl_wr & ~sw_busy & (s_axi_wdata[`CTL_PROC] | s_axi_wdata[`CTL_PERIPH] |
                  s_axi_wdata[`CTL_EXT]);
assign sw_ext = sw_start & s_axi_wdata[`CTL_EXT];

// RULE4 independent commands
always @(posedge aclk) begin
  if (!aresetn) begin
    sw_cnt_r <= 3'h0;
    sw_proc_r <= 1'b0;
    sw_periph_r <= 1'b0;
  end else if (sw_start) begin
    sw_cnt_r <= `SW_RESET_CYC;
    sw_proc_r <= s_axi_wdata[`CTL_PROC];
    sw_periph_r <= s_axi_wdata[`CTL_PERIPH];
  end else if (sw_busy) begin
    sw_cnt_r <= sw_cnt_r - 3'h1;
    if (sw_cnt_r == 3'h1) begin
      sw_proc_r <= 1'b0;
      sw_periph_r <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// pin drive pulse

reg [`EXT_CNT_W-1:0] ext_cnt_r;
reg [`EXT_CNT_W-1:0] ext_cnt_nxt;
reg self_r;
reg [3:0] oe_hist_r;
reg ext_done;
wire ext_start;

assign ext_start = ext_reset_req | sw_ext;

// RULE13 length is 2^(len+1)
always @* begin
  ext_done = 1'b0;
  ext_cnt_nxt = ext_cnt_r;
  if (ext_start) begin
    ext_cnt_nxt = `EXT_CNT_ONE << ({1'b0, len_field} + 5'h01);
  end else if (ext_cnt_r != {`EXT_CNT_W{1'b0}}) begin
    ext_cnt_nxt = ext_cnt_r - `EXT_CNT_ONE;
    ext_done = (ext_cnt_r == `EXT_CNT_ONE);
  end
end

// RULE12 hold pin low
always @(posedge aclk) begin
  if (!aresetn) begin
    ext_cnt_r <= {`EXT_CNT_W{1'b0}};
    reset_pin_oe <= 1'b0;
  end else begin
    ext_cnt_r <= ext_cnt_nxt;
    reset_pin_oe <= (ext_cnt_nxt != {`EXT_CNT_W{1'b0}});
  end
end

// the filtered level trails the pin by four clocks; a high level seen sooner is stale
always @(posedge aclk) begin
  if (!aresetn) begin
    oe_hist_r <= 4'h0;
  end else begin
    oe_hist_r <= {oe_hist_r[2:0], reset_pin_oe};
  end
end

// our own pulse must not come back as a user reset; cleared once the pin reads high
always @(posedge aclk) begin
  if (!aresetn) begin
    self_r <= 1'b0;
  end else if (ext_start) begin
    self_r <= 1'b1;
  end else if (!reset_pin_oe && (oe_hist_r == 4'h0) && pin_level) begin
    self_r <= 1'b0;
  end
end

// RULE17 open drain
assign reset_pin_o = 1'b0;

////////////////////////////////////////////////////////////////////////////////
// user reset sequence

reg [3:0] ustate_r;
reg [3:0] ustate_nxt;
reg [2:0] ucnt_r;
reg [2:0] ucnt_nxt;
wire user_trig;
wire user_go;

// RULE7 low pin reported
assign user_trig = pin_fall & ~self_r & ~sw_busy;
// RULE8 enable gate
// RULE11 irq replaces reset
assign user_go = user_trig & urst_en & ~urst_irq_en;

always @* begin
  ustate_nxt = ustate_r;
  ucnt_nxt = ucnt_r;
  case (ustate_r)
    U_IDLE: begin
      if (user_go) begin
        ustate_nxt = U_HOLD;
      end
    end
    // RULE15 wait for pin high
    U_HOLD: begin
      if (pin_level) begin
        ustate_nxt = U_RESYNC;
        ucnt_nxt = `URST_RESYNC_CYC - 3'h1;
      end
    end
    // RULE14 resync then startup
    U_RESYNC: begin
      if (ucnt_r == 3'h0) begin
        ustate_nxt = U_START;
        ucnt_nxt = `URST_START_CYC - 3'h1;
      end else begin
        ucnt_nxt = ucnt_r - 3'h1;
      end
    end
    U_START: begin
      if (ucnt_r == 3'h0) begin
        ustate_nxt = U_IDLE;
      end else begin
        ucnt_nxt = ucnt_r - 3'h1;
      end
    end
    default: begin
      ustate_nxt = U_IDLE;
      ucnt_nxt = 3'h0;
    end
  endcase
end

always @(posedge aclk) begin
  if (!aresetn) begin
    ustate_r <= U_IDLE;
    ucnt_r <= 3'h0;
    user_reset_req <= 1'b0;
  end else begin
    ustate_r <= ustate_nxt;
    ucnt_r <= ucnt_nxt;
    user_reset_req <= (ustate_nxt == U_HOLD);
  end
end

////////////////////////////////////////////////////////////////////////////////
// reset outputs, status and interrupts

wire user_active;
wire proc_nxt_n;

assign user_active = (ustate_nxt != U_IDLE);
// RULE1 registered lines
// RULE17 active low
assign proc_nxt_n = ~(user_active | (sw_proc_r & ~(sw_cnt_r == 3'h1)));

// RULE3 separate peripheral line
always @(posedge aclk) begin
  if (!aresetn) begin
    proc_reset_n <= 1'b0;
    periph_reset_n <= 1'b0;
  end else begin
    proc_reset_n <= proc_nxt_n;
    periph_reset_n <= ~(user_active | (sw_periph_r & ~(sw_cnt_r == 3'h1)));
  end
end

// RULE2 watchdog follows processor
assign watchdog_reset_n = proc_reset_n;

// RULE16 type on release
always @(posedge aclk) begin
  if (!aresetn) begin
    type_r <= `TYPE_POWER_UP;
  end else if (!proc_reset_n && proc_nxt_n) begin
    // leaving power-up reset keeps its code
    if (ustate_r == U_START) begin
      type_r <= `TYPE_USER;
    end else if (sw_proc_r) begin
      type_r <= `TYPE_SOFT;
    end
  end
end

// RULE10 sticky, set beats read clear
always @(posedge aclk) begin
  if (!aresetn) begin
    seen_r <= 1'b0;
  end else if (pin_fall) begin
    seen_r <= 1'b1;
  end else if (sts_rd) begin
    seen_r <= 1'b0;
  end
end

// write one to clear; a new event in the same cycle wins
always @(posedge aclk) begin
  if (!aresetn) begin
    irq_sts_r <= {`IRQ_W{1'b0}};
  end else begin
    if (irq_wr && s_axi_wdata[`IRQ_PIN]) begin
      irq_sts_r[`IRQ_PIN] <= 1'b0;
    end
    if (irq_wr && s_axi_wdata[`IRQ_EXT_DONE]) begin
      irq_sts_r[`IRQ_EXT_DONE] <= 1'b0;
    end
    // RULE11 pin interrupt
    if (user_trig && urst_irq_en) begin
      irq_sts_r[`IRQ_PIN] <= 1'b1;
    end
    if (ext_done) begin
      irq_sts_r[`IRQ_EXT_DONE] <= 1'b1;
    end
  end
end

assign irq = |(irq_sts_r & irq_mask_r);

endmodule // reset_pin_manager

// [bench/reset_pin_manager_asserts.sv]
// checker: port timing of the reset pin manager
// assumes bind to the top module, one clock
`timescale 1ns/1ps
module reset_pin_manager_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic ext_reset_req,
  input wire logic user_reset_req,
  input wire logic proc_reset_n,
  input wire logic periph_reset_n,
  input wire logic watchdog_reset_n,
  input wire logic reset_pin_o,
  input wire logic reset_pin_oe
);
  logic [16:0] oe_cnt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // length of the current pin drive; a restart would break the power-of-two check
  always @(posedge aclk) begin
    if (!aresetn || !reset_pin_oe) begin
      oe_cnt <= 17'h0_0000;
    end else begin
      oe_cnt <= oe_cnt + 17'h0_0001;
    end
  end
  ////////////////////////////////////////
  wdog_follow_a: assert property (watchdog_reset_n == proc_reset_n)
    else $error("watchdog reset differs from processor reset");
  pin_drive_a: assert property (reset_pin_o == 1'b0)
    else $error("pin output not low");
  ext_start_a: assert property (ext_reset_req |=> reset_pin_oe)
    else $error("pin not driven after request");
  oe_length_a: assert property ($fell(reset_pin_oe) |->
    oe_cnt >= 17'h0_0002 && (oe_cnt & (oe_cnt - 17'h0_0001)) == 17'h0_0000)
    else $error("pin drive length not a power of two");
  user_enter_a: assert property ($rose(user_reset_req) |->
    ##[0:1] (!proc_reset_n && !periph_reset_n))
    else $error("user reset without internal resets");
  user_hold_a: assert property (user_reset_req && $past(user_reset_req) |->
    !proc_reset_n && !periph_reset_n)
    else $error("internal resets released during user reset");
  user_exit_a: assert property ($fell(user_reset_req) |->
    !proc_reset_n [*3] ##[1:6] proc_reset_n)
    else $error("user reset exit timing wrong");
  write_answer_a: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready
    |=> s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  aw_pair_a: assert property (s_axi_awready |->
    s_axi_wready && s_axi_awvalid && s_axi_wvalid)
    else $error("address and data not taken together");
endmodule // reset_pin_manager_asserts

// [bench/reset_pin_partner.sv]
// partner: reset switch and outside devices on the open-drain reset pin
// assumes a pull-up on the line; the device pulls low through its enable
`timescale 1ns/1ps
module reset_pin_partner (
  input wire logic aclk,
  input wire logic press,
  input wire logic [7:0] stretch,
  input wire logic dev_o,
  input wire logic dev_oe,
  output wire logic pin
);
  int hold = 0;
  // an outside device keeps the line low a while after the device lets go
  always @(posedge aclk) begin
    if (dev_oe) begin
      hold <= int'(stretch);
    end else if (hold > 0) begin
      hold <= hold - 1;
    end
  end
  assign pin = !((dev_oe && !dev_o) || press || hold > 0);
endmodule // reset_pin_partner

// [bench/reset_pin_manager_tb.sv]
// testbench: registers, pin pulses, user reset, interrupt and software resets
// assumes the partner model on the pin and the checker bound below
`timescale 1ns/1ps
`include "reset_pin_manager_defs.vh"
module reset_pin_manager_tb;
  logic aclk = 1'b0, aresetn = 1'b0, ext_reset_req = 1'b0, press = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0, rv;
  logic [7:0] lf = 8'h04, stretch = 8'h00;
  logic [1:0] rr;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire user_reset_req, proc_reset_n, periph_reset_n, watchdog_reset_n;
  wire reset_pin_i, reset_pin_o, reset_pin_oe, irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int n_fail = 0, n_compared = 0, n, ln;
  logic [2:0] exp_type = `TYPE_POWER_UP;

  reset_pin_manager u_dut(.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_reset_req, .user_reset_req,
    .proc_reset_n, .periph_reset_n, .watchdog_reset_n, .reset_pin_i, .reset_pin_o,
    .reset_pin_oe, .irq);
  reset_pin_partner u_far(.aclk, .press, .stretch, .dev_o(reset_pin_o),
    .dev_oe(reset_pin_oe), .pin(reset_pin_i));

  initial begin
    forever #12.5 aclk = ~aclk;
  end
  ////////////////////////////////////////
  function automatic logic [7:0] nx(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // status word as the model expects it, pin idle high
  function automatic logic [31:0] sts(input logic s, input logic [2:0] t);
    return {15'h0000, 1'h1, 5'h00, t, 7'h00, s};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ready is held high, so a response is taken at the edge it is seen
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk(s_axi_bresp, `RESP_OKAY);
  endtask
  task automatic rd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic push(input int k);
    press <= 1'b1;
    repeat (k) @(posedge aclk);
  endtask
  task automatic release_wait();
    press <= 1'b0;
    repeat (30) @(posedge aclk);
  endtask
  task automatic count_oe();
    // a pulse started by a register write is already up on entry
    n = int'(reset_pin_oe);
    repeat (60) begin
      @(posedge aclk);
      n += int'(reset_pin_oe);
    end
  endtask
  task complete_run;
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`OFS_MODE);
    chk(rv, `MODE_RESET);
    rd(`OFS_STATUS);
    chk(rv, sts(1'b0, exp_type));
    rd(4'h2);
    chk({rr, rv[29:0]}, {`RESP_SLVERR, 30'h0});
    for (ln = 0; ln < 4; ln++) begin
      lf = nx(lf);
      stretch <= {5'h00, lf[2:0]};
      wr(`OFS_MODE, 32'h0000_0001 | (ln << 8));
      ext_reset_req <= 1'b1;
      @(posedge aclk);
      ext_reset_req <= 1'b0;
      count_oe();
      chk(n, 1 << (ln + 1));
      rd(`OFS_STATUS);
      chk(rv, sts(1'b1, exp_type));
    end
    rd(`OFS_STATUS);
    chk(rv, sts(1'b0, exp_type));
    rd(`OFS_IRQ_STATUS);
    chk(rv, 32'h0000_0002);
    wr(`OFS_IRQ_STATUS, 32'h0000_0003);
    wr(`OFS_MODE, 32'h0000_0001);
    lf = nx(lf);
    push(12 + lf[3:0]);
    chk(user_reset_req, 1'b1);
    chk({proc_reset_n, periph_reset_n}, 2'b00);
    release_wait();
    exp_type = `TYPE_USER;
    chk(proc_reset_n, 1'b1);
    rd(`OFS_STATUS);
    chk(rv, sts(1'b1, exp_type));
    wr(`OFS_MODE, 32'h0000_0000);
    push(12);
    chk({user_reset_req, proc_reset_n}, 2'b01);
    release_wait();
    wr(`OFS_MODE, 32'h0000_0011);
    wr(`OFS_IRQ_STATUS, 32'h0001_0000);
    push(12);
    chk({user_reset_req, proc_reset_n}, 2'b01);
    release_wait();
    chk(irq, 1'b1);
    wr(`OFS_IRQ_STATUS, 32'h0001_0001);
    @(posedge aclk);
    chk(irq, 1'b0);
    // masked source still records the event
    wr(`OFS_IRQ_STATUS, 32'h0000_0000);
    push(12);
    release_wait();
    chk(irq, 1'b0);
    rd(`OFS_IRQ_STATUS);
    chk(rv, 32'h0000_0001);
    wr(`OFS_CONTROL, 32'h0000_0004);
    @(posedge aclk);
    chk({proc_reset_n, periph_reset_n}, 2'b10);
    repeat (6) @(posedge aclk);
    wr(`OFS_CONTROL, 32'h0000_0001);
    @(posedge aclk);
    chk({proc_reset_n, periph_reset_n}, 2'b01);
    repeat (6) @(posedge aclk);
    rd(`OFS_STATUS);
    chk(rv[10:8], `TYPE_SOFT);
    // both lines at once, busy visible while the command runs
    wr(`OFS_CONTROL, 32'h0000_0005);
    rd(`OFS_STATUS);
    chk(rv, sts(1'b0, `TYPE_SOFT) | 32'h0002_0000);
    chk({proc_reset_n, periph_reset_n}, 2'b00);
    repeat (6) @(posedge aclk);
    wr(`OFS_CONTROL, 32'h0000_0008);
    count_oe();
    chk(n, 2);
    complete_run;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    complete_run;
  end
endmodule // reset_pin_manager_tb

bind reset_pin_manager reset_pin_manager_asserts u_chk(.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_wvalid, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .ext_reset_req, .user_reset_req, .proc_reset_n,
  .periph_reset_n, .watchdog_reset_n, .reset_pin_o, .reset_pin_oe);
